// ===== src/pcic_pkg.sv
/*
 * Shared constants and carrier types for the pixel calibration injection control.
 * Assumes a single 250 MHz system clock and a same-clock command decoder upstream.
 */
package pcic_pkg;

    // System clock period in picoseconds (250 MHz)
    localparam int unsigned CLK_PERIOD_PS = 4000;

    // Injection pattern select encodings
    localparam logic PATTERN_UNIFORM   = 1'b0;
    localparam logic PATTERN_ALTERNATE = 1'b1;
    localparam logic PATTERN_RESET     = PATTERN_UNIFORM;

    // Per-pixel calibration enable after reset: blocked
    localparam logic CAL_ENABLE_RESET = 1'b0;

    // Baseline acquisition length, ns, and its cycle count (least time: round up)
    localparam int unsigned BASELINE_ACQ_NS     = 100;
    localparam int unsigned BASELINE_ACQ_CYCLES =
        (BASELINE_ACQ_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Longest spacing between acquisitions, us, and its count (longest: round down)
    localparam int unsigned BASELINE_MAX_US         = 100;
    localparam int unsigned BASELINE_MAX_CYCLES_DEF =
        (BASELINE_MAX_US * 1000000) / CLK_PERIOD_PS;

    // Allowed skew of the timing pulse across pixels, ps
    localparam int unsigned PULSE_SKEW_MAX_PS = 2000;

    // Distributed calibration control pair
    typedef struct packed {
        logic edge_pulse;   // Timing-critical calibration pulse
        logic aux_level;    // Auxiliary level, loose timing
    } pcic_cal_t;

    // Switch control pair of one pixel
    typedef struct packed {
        logic inject_switch_first;
        logic inject_switch_second;
    } pcic_sw_t;

endpackage

// ===== src/pcic_switch_gen.sv
/*
 * Switch control equations of one pixel, purely combinational.
 * Assumes the calibration pair is already phase adjusted and distributed.
 */
`timescale 1ns/10ps
module pcic_switch_gen (
    input  wire pcic_pkg::pcic_cal_t cal_i,      // Distributed calibration pair
    input  wire logic                odd_i,      // Pixel parity, row + column odd
    input  wire logic                alt_mode_i, // Pattern select
    output pcic_pkg::pcic_sw_t       sw_o        // Switch controls
);
    import pcic_pkg::*;

    logic rise_term;  // Pulse OR aux
    logic fall_term;  // Not pulse AND aux

    // Both terms are built from the live pair so the pulse edge keeps its phase
    assign rise_term = cal_i.edge_pulse | cal_i.aux_level;    // [RQ1] [RQ17]
    assign fall_term = ~cal_i.edge_pulse & cal_i.aux_level;   // [RQ1] [RQ17]

    // Odd pixels swap the terms only when alternating is selected
    always_comb begin
        if (alt_mode_i == PATTERN_ALTERNATE && odd_i) begin   // [RQ2] [RQ4]
            sw_o.inject_switch_first  = fall_term;
            sw_o.inject_switch_second = rise_term;
        end else begin                                        // [RQ1] [RQ14]
            sw_o.inject_switch_first  = rise_term;
            sw_o.inject_switch_second = fall_term;
        end
    end

endmodule

// ===== src/pcic_baseline_seq.sv
/*
 * Baseline acquisition window generator and overdue watch.
 * Assumes the trigger is a one-cycle pulse from same-clock logic.
 */
`timescale 1ns/10ps
module pcic_baseline_seq #(
    parameter int unsigned MAX_CYCLES = pcic_pkg::BASELINE_MAX_CYCLES_DEF
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic trigger_i,   // Start one acquisition
    output logic      acquire_o,   // Acquisition window level
    output logic      overdue_o    // Spacing limit exceeded
);
    import pcic_pkg::*;

    localparam int unsigned WIN_W = $clog2(BASELINE_ACQ_CYCLES + 1);
    localparam int unsigned GAP_W = $clog2(MAX_CYCLES + 1);
    localparam logic [WIN_W-1:0] WIN_LOAD = WIN_W'(BASELINE_ACQ_CYCLES);
    localparam logic [GAP_W-1:0] GAP_MAX  = GAP_W'(MAX_CYCLES);

    logic [WIN_W-1:0] win_reg;  // Cycles left in the window
    logic [GAP_W-1:0] gap_reg;  // Cycles since the last window began

    // Window counter; a trigger inside a window restarts it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            win_reg <= '0;
        end else if (trigger_i) begin
            win_reg <= WIN_LOAD;                              // [RQ16]
        end else if (win_reg != '0) begin
            win_reg <= win_reg - WIN_W'(1);
        end
    end

    // Spacing counter saturates so the flag stays until the next trigger
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gap_reg <= '0;
        end else if (trigger_i) begin
            gap_reg <= '0;
        end else if (gap_reg != GAP_MAX) begin
            gap_reg <= gap_reg + GAP_W'(1);
        end
    end

    // Registered outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acquire_o <= 1'b0;
            overdue_o <= 1'b0;
        end else begin
            acquire_o <= trigger_i | (win_reg > WIN_W'(1));
            overdue_o <= ~trigger_i & (gap_reg == GAP_MAX);  // [RQ16]
        end
    end

endmodule

// ===== src/pcic_top.sv
/*
 * Pixel calibration injection control for a ROWS x COLS pixel block.
 * Holds the global pattern select and fine delay, per-pixel enables,
 * derives both switch controls per pixel and flags each injection.
 * Assumes the command decoder runs on the same clock and drives the
 * calibration pulse and auxiliary level with the ordering it owes.
 */
// Behaviour
// RQ1: Uniform first = pulse|aux, second = ~pulse&aux.
// RQ2: Alternating: odd pixels swap the two equations.
// RQ3: Parity of row plus column sets odd/even.
// RQ4: Pattern bit: 0 uniform, 1 alternating.
// RQ5: Uniform is the reset default pattern.
// RQ6: Inject on enabled pixel switch rising edge.
// RQ7: Each pixel has its own calibration enable.
// RQ8: Switch assignment ignores the enable bit.
// RQ9: Decoder primes explicitly; device never self-primes.
// RQ10: Decoder leaves settling time after priming.
// RQ11: Pulse reaches every pixel within 2 ns.
// RQ12: One chip-wide fine phase delay on pulse.
// RQ13: Aux starts low, rises after the pulse.
// RQ14: Uniform: pulse rise first switch, fall second.
// RQ15: Two pulses without priming; first alone single.
// RQ16: Baseline acquisition often enough, 100 ns each.
// RQ17: Switch equations combinational, no added registering.
`timescale 1ns/10ps
module pcic_top #(
    parameter int unsigned ROWS        = 4,     // Pixel rows in this block
    parameter int unsigned COLS        = 4,     // Pixel columns in this block
    parameter int unsigned DELAY_TAPS  = 16,    // Fine delay settings
    parameter int unsigned BASELINE_MAX_CYCLES = pcic_pkg::BASELINE_MAX_CYCLES_DEF
) (
    input  wire logic                          SYS_CLK_I,
    input  wire logic                          RESET_I,
    input  wire pcic_pkg::pcic_cal_t           CAL_I,           // Pulse and aux from decoder
    input  wire logic                          CFG_MODE_WE_I,   // Load pattern select
    input  wire logic                          CFG_MODE_I,      // Pattern select value
    input  wire logic                          CFG_DELAY_WE_I,  // Load fine delay
    input  wire logic [$clog2(DELAY_TAPS)-1:0] CFG_DELAY_I,     // Fine delay value
    input  wire logic                          CFG_EN_WE_I,     // Load one pixel enable
    input  wire logic [$clog2(ROWS)-1:0]       CFG_ROW_I,       // Row of that pixel
    input  wire logic [$clog2(COLS)-1:0]       CFG_COL_I,       // Column of that pixel
    input  wire logic                          CFG_EN_I,        // Enable value
    input  wire logic                          BASELINE_TRIG_I, // Start acquisition
    output logic [ROWS*COLS-1:0]               SWITCH_FIRST_O,  // First switch per pixel
    output logic [ROWS*COLS-1:0]               SWITCH_SECOND_O, // Second switch per pixel
    output logic [ROWS*COLS-1:0]               INJECT_O,        // Injection event per pixel
    output logic                               MODE_O,          // Current pattern select
    output logic                               BASELINE_ACQ_O,  // Acquisition window
    output logic                               BASELINE_LATE_O  // Spacing exceeded
);
    import pcic_pkg::*;

    localparam int unsigned NPIX = ROWS * COLS;
    localparam int unsigned DW   = $clog2(DELAY_TAPS);
    localparam int unsigned IW   = $clog2(NPIX);

    // Parity of a pixel from its coordinates
    function automatic logic pixel_odd(input int unsigned row, input int unsigned col);
        logic [31:0] sum;
        sum = row + col;
        return sum[0];                                        // [RQ3]
    endfunction

    logic                  mode_reg;          // Pattern select, chip-wide
    logic [DW-1:0]         delay_reg;         // Fine delay, chip-wide
    logic [NPIX-1:0]       enable_reg;        // Per-pixel calibration enables
    logic [DELAY_TAPS-2:0] pulse_line_reg;    // Pulse delay line, tap 0 is one cycle
    logic [IW-1:0]         en_index;          // Flat index of the pixel being written
    logic                  pulse_delayed;     // Selected pulse phase
    pcic_cal_t             cal_dist;          // Pair sent to every pixel
    logic [NPIX-1:0]       first_now;         // Live first switch per pixel
    logic [NPIX-1:0]       second_now;        // Live second switch per pixel
    logic [NPIX-1:0]       first_prev_reg;    // Previous first switch
    logic [NPIX-1:0]       second_prev_reg;   // Previous second switch

    // Pattern select; uniform out of reset
    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            mode_reg <= PATTERN_RESET;                        // [RQ5]
        end else if (CFG_MODE_WE_I) begin
            mode_reg <= CFG_MODE_I;                           // [RQ4]
        end
    end

    // One delay setting for the whole block, never per pixel
    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            delay_reg <= '0;
        end else if (CFG_DELAY_WE_I) begin
            delay_reg <= CFG_DELAY_I;                         // [RQ12]
        end
    end

    // Flat pixel index; widened first so COLS itself is never cut to the column width
    assign en_index = IW'(CFG_ROW_I) * IW'(COLS) + IW'(CFG_COL_I);

    // Per-pixel enables written one at a time by coordinate
    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            enable_reg <= {NPIX{CAL_ENABLE_RESET}};
        end else if (CFG_EN_WE_I) begin
            enable_reg[en_index] <= CFG_EN_I;                 // [RQ7]
        end
    end

    // Pulse delay line; the aux level needs no phase care so it bypasses it
    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            pulse_line_reg <= '0;
        end else begin
            pulse_line_reg <= {pulse_line_reg[DELAY_TAPS-3:0], CAL_I.edge_pulse};
        end
    end

    // Setting zero passes the pulse straight through with no added latency
    always_comb begin
        if (delay_reg == '0) begin
            pulse_delayed = CAL_I.edge_pulse;
        end else begin
            pulse_delayed = pulse_line_reg[delay_reg - DW'(1)];  // [RQ12]
        end
    end

    // A single shared copy feeds all pixels, so every pixel sees one edge
    assign cal_dist.edge_pulse = pulse_delayed;               // [RQ11]
    assign cal_dist.aux_level  = CAL_I.aux_level;             // [RQ13]

    // Per-pixel switch derivation, independent of the enables
    generate
        for (genvar r = 0; r < ROWS; r++) begin : g_row
            for (genvar c = 0; c < COLS; c++) begin : g_col
                pcic_sw_t sw;
                pcic_switch_gen u_sw (
                    .cal_i      (cal_dist),
                    .odd_i      (pixel_odd(r, c)),            // [RQ3]
                    .alt_mode_i (mode_reg),
                    .sw_o       (sw)
                );
                // Enable plays no part here, only in the event below
                assign first_now[r*COLS+c]  = sw.inject_switch_first;   // [RQ8]
                assign second_now[r*COLS+c] = sw.inject_switch_second;  // [RQ8]
            end
        end
    endgenerate

    // Switch pins follow the live equations; a register here would drop the fine phase
    assign SWITCH_FIRST_O  = first_now;                       // [RQ17]
    assign SWITCH_SECOND_O = second_now;                      // [RQ17]

    // History of the switches; reset value high means no prime has happened yet
    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            first_prev_reg  <= '1;
            second_prev_reg <= '1;
        end else begin
            first_prev_reg  <= first_now;
            second_prev_reg <= second_now;
        end
    end

    // Injection event: enabled pixel and a low-to-high switch move
    // Nothing here lowers a switch on its own, so priming stays with the decoder
    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            INJECT_O <= '0;
        end else begin
            INJECT_O <= enable_reg &                          // [RQ6] [RQ9]
                        ((first_now & ~first_prev_reg) |
                         (second_now & ~second_prev_reg));    // [RQ15]
        end
    end

    // Current pattern shown outward
    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            MODE_O <= PATTERN_RESET;
        end else begin
            MODE_O <= mode_reg;
        end
    end

    // Baseline refresh window for the synchronous front ends
    pcic_baseline_seq #(
        .MAX_CYCLES (BASELINE_MAX_CYCLES)
    ) u_baseline (
        .clk_i     (SYS_CLK_I),
        .rst_i     (RESET_I),
        .trigger_i (BASELINE_TRIG_I),                         // [RQ16]
        .acquire_o (BASELINE_ACQ_O),
        .overdue_o (BASELINE_LATE_O)
    );

endmodule

// ===== dv/pcic_top_asserts.sv
/* Port checker for pcic_top, bound into every instance.
   Assumes it sees the same clock, reset and ports as the block. */
`timescale 1ns/10ps
module pcic_top_asserts import pcic_pkg::*; #(
    parameter int unsigned ROWS                = 4,
    parameter int unsigned COLS                = 4,
    parameter int unsigned DELAY_TAPS          = 16,
    parameter int unsigned BASELINE_MAX_CYCLES = pcic_pkg::BASELINE_MAX_CYCLES_DEF
) (
    input wire logic                          SYS_CLK_I,
    input wire logic                          RESET_I,
    input wire pcic_cal_t                     CAL_I,
    input wire logic                          CFG_MODE_WE_I,
    input wire logic                          CFG_MODE_I,
    input wire logic                          CFG_DELAY_WE_I,
    input wire logic [$clog2(DELAY_TAPS)-1:0] CFG_DELAY_I,
    input wire logic                          CFG_EN_WE_I,
    input wire logic [$clog2(ROWS)-1:0]       CFG_ROW_I,
    input wire logic [$clog2(COLS)-1:0]       CFG_COL_I,
    input wire logic                          CFG_EN_I,
    input wire logic                          BASELINE_TRIG_I,
    input wire logic [ROWS*COLS-1:0]          SWITCH_FIRST_O,
    input wire logic [ROWS*COLS-1:0]          SWITCH_SECOND_O,
    input wire logic [ROWS*COLS-1:0]          INJECT_O,
    input wire logic                          MODE_O,
    input wire logic                          BASELINE_ACQ_O,
    input wire logic                          BASELINE_LATE_O
);
    localparam int N  = ROWS * COLS;
    localparam int LO = BASELINE_MAX_CYCLES - 2;
    localparam int HI = BASELINE_MAX_CYCLES + 2;
    logic [N-1:0] odd_m;  // Odd parity pixels
    logic [N-1:0] en_h;   // Shadow of pixel enables
    logic [N-1:0] por;    // Pulse or aux
    logic [N-1:0] npa;    // Not pulse and aux
    logic         mode_h; // Shadow of pattern select
    logic         dly0_h; // Fine delay is zero, so switches are combinational
    int           left;   // Acquisition cycles still owed
    int           idle;   // Cycles since last trigger, saturating
    always_comb begin
        for (int i = 0; i < N; i++) begin
            odd_m[i] = (((i / COLS) + (i % COLS)) % 2) == 1;
        end
    end
    assign por = {N{CAL_I.edge_pulse | CAL_I.aux_level}};
    assign npa = {N{~CAL_I.edge_pulse & CAL_I.aux_level}};
    // Shadow configuration, taken on the same edges as the block
    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            en_h <= '0;
        end else if (CFG_EN_WE_I) begin
            en_h[CFG_ROW_I * COLS + CFG_COL_I] <= CFG_EN_I;
        end
    end
    always_ff @(posedge SYS_CLK_I) begin
        mode_h <= RESET_I ? 1'b0 : (CFG_MODE_WE_I ? CFG_MODE_I : mode_h);
        dly0_h <= RESET_I ? 1'b1 : (CFG_DELAY_WE_I ? (CFG_DELAY_I == 0) : dly0_h);
    end
    // Baseline window and spacing counters; idle saturates to stay small
    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            left <= 0;
        end else if (BASELINE_TRIG_I) begin
            left <= int'(BASELINE_ACQ_CYCLES);
        end else if (left != 0) begin
            left <= left - 1;
        end
        idle <= (RESET_I || BASELINE_TRIG_I) ? 0 : (idle < HI + 1 ? idle + 1 : idle);
    end
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (RESET_I);
    chk_uni_first: assert property (dly0_h && !mode_h |-> SWITCH_FIRST_O == por)
        else $error("uniform first switch wrong");
    chk_uni_second: assert property (dly0_h && !mode_h |-> SWITCH_SECOND_O == npa)
        else $error("uniform second switch wrong");
    chk_alt_first: assert property (dly0_h && mode_h |->
        SWITCH_FIRST_O == ((por & ~odd_m) | (npa & odd_m))) else $error("alt first switch wrong");
    chk_alt_second: assert property (dly0_h && mode_h |->
        SWITCH_SECOND_O == ((npa & ~odd_m) | (por & odd_m))) else $error("alt second wrong");
    chk_mode_shown: assert property (CFG_MODE_WE_I |-> ##2 MODE_O == $past(CFG_MODE_I, 2))
        else $error("pattern select not shown");
    chk_mode_default: assert property ($fell(RESET_I) |-> !MODE_O)
        else $error("pattern select not uniform after reset");
    chk_inject_rise: assert property (!$past(RESET_I) |=> INJECT_O == ($past(en_h) &
        (($past(SWITCH_FIRST_O) & ~$past(SWITCH_FIRST_O, 2)) |
         ($past(SWITCH_SECOND_O) & ~$past(SWITCH_SECOND_O, 2))))) else $error("inject wrong");
    chk_acq_window: assert property (BASELINE_ACQ_O == (left != 0))
        else $error("acquisition window wrong");
    chk_late_early: assert property (idle < LO |-> !BASELINE_LATE_O)
        else $error("late flag too early");
    chk_late_set: assert property (idle > HI |-> BASELINE_LATE_O)
        else $error("late flag missing");
    cover property (INJECT_O != '0);
    cover property (mode_h && CAL_I.aux_level);
    cover property ($rose(BASELINE_LATE_O));
endmodule
bind pcic_top pcic_top_asserts #(.ROWS(ROWS), .COLS(COLS), .DELAY_TAPS(DELAY_TAPS),
    .BASELINE_MAX_CYCLES(BASELINE_MAX_CYCLES)) i_pcic_top_asserts (.*);

// ===== dv/pcic_dec_model.sv
/* Command decoder model driving the calibration pair.
   Assumes go_i is raised for one cycle while busy_o is low. */
`timescale 1ns/10ps
module pcic_dec_model import pcic_pkg::*; (
    input  wire logic       clk_i,
    input  wire logic       go_i,     // Start prime then inject
    input  wire logic       double_i, // Also throw the second switch
    input  wire logic [2:0] hold_i,   // Cycles per step, 4 or more
    output pcic_cal_t       cal_o,
    output logic            busy_o
);
    // One step of the command, changed just after a falling edge
    task automatic step(input logic p, input logic a);
        @(negedge clk_i);
        cal_o = '{edge_pulse: p, aux_level: a};
        repeat (hold_i - 1) @(negedge clk_i);
    endtask
    initial begin
        cal_o  = '0;
        busy_o = 1'b0;
        forever begin
            @(posedge clk_i);
            if (go_i) begin
                busy_o = 1'b1;
                step(1'b0, 1'b0); // Prime low, then let it settle
                step(1'b1, 1'b0); // Pulse rises while aux is still low
                step(1'b1, 1'b1); // Aux follows loosely
                if (double_i) begin
                    step(1'b0, 1'b1); // Pulse falls: second switch
                end
                step(1'b0, 1'b0);
                busy_o = 1'b0;
            end
        end
    end
endmodule

// ===== dv/tb_top.sv
/* Self-checking bench for pcic_top with a decoder model.
   Assumes one 250 MHz clock and a short baseline spacing limit. */
`timescale 1ns/10ps
module tb_top;
    import pcic_pkg::*;
    localparam int unsigned MAXC = 50;
    logic        clk, rst, mwe, mode, dwe, ewe, en, trig, go, dbl, busy, mode_o, acq, late;
    logic [3:0]  dly;
    logic [1:0]  row, col;
    logic [2:0]  hold;
    logic [15:0] sw1, sw2, inj, env;
    pcic_cal_t   cal;
    logic [15:0] expq[$]; // Expected injection vectors, oldest first
    int          fails, checked, cyc, n;
    pcic_top #(.BASELINE_MAX_CYCLES(MAXC)) i_pcic_top (.SYS_CLK_I(clk), .RESET_I(rst),
        .CAL_I(cal), .CFG_MODE_WE_I(mwe), .CFG_MODE_I(mode), .CFG_DELAY_WE_I(dwe),
        .CFG_DELAY_I(dly), .CFG_EN_WE_I(ewe), .CFG_ROW_I(row), .CFG_COL_I(col), .CFG_EN_I(en),
        .BASELINE_TRIG_I(trig), .SWITCH_FIRST_O(sw1), .SWITCH_SECOND_O(sw2), .INJECT_O(inj),
        .MODE_O(mode_o), .BASELINE_ACQ_O(acq), .BASELINE_LATE_O(late));
    pcic_dec_model i_pcic_dec_model (.clk_i(clk), .go_i(go), .double_i(dbl), .hold_i(hold),
        .cal_o(cal), .busy_o(busy));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Start a command and note each injection it should cause
    task automatic launch(input logic d);
        expq.push_back(env);
        if (d) expq.push_back(env);
        @(negedge clk);
        dbl  = d;
        hold = 3'($urandom_range(4, 7));
        go   = 1'b1;
        @(negedge clk);
        go = 1'b0;
    endtask
    task automatic finish_cmd();
        for (int k = 0; k < 200 && busy !== 1'b0; k++) @(posedge clk);
        repeat (3) @(negedge clk);
    endtask
    task automatic pulse_cfg(ref logic we);
        @(negedge clk);
        we = 1'b1;
        @(negedge clk);
        we = 1'b0;
    endtask
    // Watcher: every injection seen takes the oldest note
    always @(posedge clk) begin
        #1;
        if (rst === 1'b0 && inj !== 16'h0) begin
            check("inject", expq.size() ? expq.pop_front() : 0, inj);
        end
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc > 3000) begin
            fails++;
            complete_run();
        end
    end
    initial begin
        {rst, mwe, mode, dwe, dly, ewe, row, col, en, trig, go, dbl} = 17'h10000;
        hold = 3'h4;
        void'($urandom(32'h4cd4d894));
        repeat (5) @(negedge clk);
        rst = 1'b0;
        check("mode_o", 0, mode_o);
        check("late", 0, late);
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            @(negedge clk);
            {row, col} = 4'(i);
            en = (i == 5) ? 1'b1 : 1'($urandom);
            env[i] = en;
            ewe = 1'b1;
        end
        @(negedge clk);
        ewe = 1'b0;
        $display("test enables done");
        for (int m = 0; m < 2; m++) begin
            mode = 1'(m);
            pulse_cfg(mwe);
            @(negedge clk);
            check("mode_o", m, mode_o);
            for (int d = 0; d < 2; d++) begin
                launch(1'(d));
                finish_cmd();
            end
            $display("test pattern %0d done", m);
        end
        mode = 1'b0;
        pulse_cfg(mwe);
        dly = 4'h3;
        pulse_cfg(dwe);
        launch(1'b0);
        for (int k = 0; k < 50 && cal.edge_pulse !== 1'b1; k++) @(posedge clk);
        @(posedge clk);
        #1 check("delayed first", 16'h0, sw1);
        @(posedge clk);
        #1 check("delayed first", 16'hffff, sw1);
        check("delayed second", 16'h0, sw2);
        finish_cmd();
        dly = 4'h0;
        pulse_cfg(dwe);
        $display("test delay done");
        pulse_cfg(trig);
        n = int'(acq);
        repeat (39) @(negedge clk) n += int'(acq);
        check("acq cycles", BASELINE_ACQ_CYCLES, n);
        repeat (MAXC + 5) @(negedge clk);
        check("late", 1, late);
        pulse_cfg(trig);
        @(negedge clk);
        check("late", 0, late);
        check("queue left", 0, expq.size());
        $display("test baseline done");
        complete_run();
    end
endmodule
